//--- logic/cxm_pkg.sv
// shared constants, register map and types for the complex oscillator and coarse mixer
package cxm_pkg;

  localparam int CXM_DW = 16;
  localparam int CXM_PATHS = 2;
  localparam int CXM_AW = 8;

  // register byte addresses
  localparam logic [7:0] CXM_CTRL_OFS = 8'h00;
  localparam logic [7:0] CXM_SYNC_OFS = 8'h04;
  localparam logic [7:0] CXM_FREQ1_OFS = 8'h08;
  localparam logic [7:0] CXM_FREQ2_OFS = 8'h0c;
  localparam logic [7:0] CXM_POFS1_OFS = 8'h10;
  localparam logic [7:0] CXM_POFS2_OFS = 8'h14;
  localparam logic [7:0] CXM_ACC1_OFS = 8'h18;
  localparam logic [7:0] CXM_ACC2_OFS = 8'h1c;

  // control word fields
  localparam int CXM_FULL_COMPLEX_MIX_BIT = 0;
  localparam int CXM_GAIN_BIT = 2;
  localparam int CXM_CMIX_LSB = 8;
  localparam int CXM_SWSYNC_BIT = 16;
  localparam logic [31:0] CXM_CTRL_MASK = 32'h0000_ff07;
  localparam logic [31:0] CXM_CTRL_RST = 32'h0000_0000;
  localparam logic [3:0] CXM_SYNC_RST = 4'h1;

  localparam logic [1:0] CXM_RESP_OKAY = 2'b00;
  localparam logic [1:0] CXM_RESP_SLVERR = 2'b10;

  // quarter sine, Q15, 17 points over 0..pi/2
  localparam logic [15:0] CXM_SIN_TBL [0:16] = '{
    16'h0000, 16'h0c8c, 16'h18f9, 16'h2528, 16'h30fb, 16'h3c56, 16'h471c, 16'h5133,
    16'h5a82, 16'h62f2, 16'h6a6d, 16'h70e2, 16'h7641, 16'h7a7c, 16'h7d8a, 16'h7f62,
    16'h7fff};

  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } cxm_iq_t;

endpackage

//--- logic/cxm_complex_nco_coarse_mixer.sv
// two-path oscillator-driven complex mixer with coarse mixer and AXI4-Lite registers
`timescale 1ns/1ns
module cxm_complex_nco_coarse_mixer
  import cxm_pkg::*;
#(
  parameter int DW = CXM_DW
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] syncPin,
  input wire cxm_iq_t pair1In,
  input wire cxm_iq_t pair2In,
  output cxm_iq_t pair1Out,
  output cxm_iq_t pair2Out
);

  // the sine table is Q15, so only a 16-bit datapath is served
  if (DW != 16)
  begin : g_chk
    $error("cxm: DW must be 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // quarter-wave lookup over a 6-bit phase
  function automatic logic signed [15:0] sinLook(input logic [5:0] ph);
    logic [15:0] mag;
    mag = ph[4] ? CXM_SIN_TBL[5'd16 - {1'b0, ph[3:0]}] : CXM_SIN_TBL[{1'b0, ph[3:0]}];
    return ph[5] ? -$signed(mag) : $signed(mag);
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [33:0] x);
    return (x > 34'sh0_7fff) ? 16'h7fff : (x < -34'sh0_8000) ? 16'h8000 : x[15:0];
  endfunction

  // negation that clips the most negative code instead of wrapping
  function automatic logic signed [15:0] negSat(input logic signed [15:0] v);
    return (v == -16'sh8000) ? 16'sh7fff : -v;
  endfunction

  // rotate a complex sample by k quarter turns
  function automatic cxm_iq_t rotQ(input cxm_iq_t s, input logic [1:0] k);
    cxm_iq_t r;
    r = s;
    case (k)
      2'd0: r = s;
      2'd1: r = '{i: negSat(s.q), q: s.i};
      2'd2: r = '{i: negSat(s.i), q: negSat(s.q)};
      2'd3: r = '{i: s.q, q: negSat(s.i)};
      default: r = s;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic awHave;
  logic wHave;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic [31:0] ctrlReg;
  logic [3:0] syncSel;
  logic [31:0] freqWord [CXM_PATHS];
  logic [15:0] phaseOff [CXM_PATHS];
  logic [31:0] acc [CXM_PATHS];
  logic swSync;

  // handshakes and write decode
  wire awFire = s_axi_awvalid & s_axi_awready;
  wire wFire = s_axi_wvalid & s_axi_wready;
  wire arFire = s_axi_arvalid & s_axi_arready;
  wire doWrite = awHave & wHave & ~s_axi_bvalid;
  wire next_awHave = (awHave & ~doWrite) | awFire;
  wire next_wHave = (wHave & ~doWrite) | wFire;
  wire next_rvalid = arFire | (s_axi_rvalid & ~s_axi_rready);
  wire wrCtrl = doWrite & (awAddr == CXM_CTRL_OFS);
  wire wrSync = doWrite & (awAddr == CXM_SYNC_OFS);
  wire wrFreq1 = doWrite & (awAddr == CXM_FREQ1_OFS);
  wire wrFreq2 = doWrite & (awAddr == CXM_FREQ2_OFS);
  wire wrPofs1 = doWrite & (awAddr == CXM_POFS1_OFS);
  wire wrPofs2 = doWrite & (awAddr == CXM_POFS2_OFS);
  wire wrHit = wrCtrl | wrSync | wrFreq1 | wrFreq2 | wrPofs1 | wrPofs2;
  wire [31:0] wMerged = mergeBytes(32'h0, wData, wStrb);

  // read decode; accumulators read live oscillator state
  wire rdHit = (s_axi_araddr[7:5] == 3'h0) && (s_axi_araddr[1:0] == 2'h0);
  wire [31:0] rdMux =
    (s_axi_araddr == CXM_CTRL_OFS) ? ctrlReg :
    (s_axi_araddr == CXM_SYNC_OFS) ? {28'h0, syncSel} :
    (s_axi_araddr == CXM_FREQ1_OFS) ? freqWord[0] :
    (s_axi_araddr == CXM_FREQ2_OFS) ? freqWord[1] :
    (s_axi_araddr == CXM_POFS1_OFS) ? {16'h0, phaseOff[0]} :
    (s_axi_araddr == CXM_POFS2_OFS) ? {16'h0, phaseOff[1]} :
    (s_axi_araddr == CXM_ACC1_OFS) ? acc[0] :
    (s_axi_araddr == CXM_ACC2_OFS) ? acc[1] : 32'h0;

  // address and data may arrive in either order; held until both are here
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0;
      wStrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      awHave <= next_awHave;
      wHave <= next_wHave;
      s_axi_awready <= ~next_awHave;
      s_axi_wready <= ~next_wHave;
      if (awFire)
      begin
        awAddr <= s_axi_awaddr;
      end
      if (wFire)
      begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
    end
  end

  // write response and read channel
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CXM_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= CXM_RESP_OKAY;
    end
    else
    begin
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? CXM_RESP_OKAY : CXM_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
      if (arFire)
      begin
        s_axi_rdata <= rdHit ? rdMux : 32'h0;
        s_axi_rresp <= rdHit ? CXM_RESP_OKAY : CXM_RESP_SLVERR;
      end
    end
  end

  // register storage; software sync bit is a one-cycle pulse and reads zero
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrlReg <= CXM_CTRL_RST;
      syncSel <= CXM_SYNC_RST;
      freqWord[0] <= 32'h0;
      freqWord[1] <= 32'h0;
      phaseOff[0] <= 16'h0;
      phaseOff[1] <= 16'h0;
      swSync <= 1'b0;
    end
    else
    begin
      swSync <= wrCtrl & wMerged[CXM_SWSYNC_BIT];
      if (wrCtrl)
      begin
        ctrlReg <= mergeBytes(ctrlReg, wData, wStrb) & CXM_CTRL_MASK;
      end
      if (wrSync)
      begin
        syncSel <= 4'(mergeBytes({28'h0, syncSel}, wData, wStrb));
      end
      if (wrFreq1)
      begin
        freqWord[0] <= mergeBytes(freqWord[0], wData, wStrb);
      end
      if (wrFreq2)
      begin
        freqWord[1] <= mergeBytes(freqWord[1], wData, wStrb);
      end
      if (wrPofs1)
      begin
        phaseOff[0] <= 16'(mergeBytes({16'h0, phaseOff[0]}, wData, wStrb));
      end
      if (wrPofs2)
      begin
        phaseOff[1] <= 16'(mergeBytes({16'h0, phaseOff[1]}, wData, wStrb));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync and shared sample counter

  logic [2:0] cnt8;
  logic [1:0] idxD;
  // bit 0 of the select is the software pulse, bits 3:1 the sync pins
  wire syncEv = |(syncSel & {syncPin, swSync});
  wire gainUnity = ctrlReg[CXM_GAIN_BIT];

  // counter gives the fs/8 phase and the coarse index
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt8 <= 3'h0;
      idxD <= 2'h0;
    end
    else
    begin
      cnt8 <= syncEv ? 3'h0 : cnt8 + 3'h1;
      idxD <= cnt8[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mixer paths: stage 1 multiplier, stage 2 coarse swap/negate

  cxm_iq_t pathIn [CXM_PATHS];
  cxm_iq_t stage1 [CXM_PATHS];
  cxm_iq_t stage2 [CXM_PATHS];
  assign pathIn[0] = pair1In;
  assign pathIn[1] = pair2In;
  assign pair1Out = stage2[0];
  assign pair2Out = stage2[1];

  for (genvar p = 0; p < CXM_PATHS; p++)
  begin : g_path
    wire full_complex_mix = ctrlReg[CXM_FULL_COMPLEX_MIX_BIT + p];
    wire [3:0] cmix = ctrlReg[CXM_CMIX_LSB + 4*p +: 4];
    // phase measured from the last clear, offset in the top 16 bits
    wire [31:0] phase = acc[p] + {phaseOff[p], 16'h0};
    // fs/8 runs the multiplier on a fixed eighth-turn step
    wire [31:0] mulPhase = cmix[3] ? {cnt8, 29'h0} : phase;
    wire useMul = full_complex_mix | cmix[3];
    wire signed [15:0] sinV = sinLook(mulPhase[31:26]);
    wire signed [15:0] cosV = sinLook(mulPhase[31:26] + 6'd16);
    wire signed [33:0] mixI = 34'(pathIn[p].i * cosV) - 34'(pathIn[p].q * sinV);
    wire signed [33:0] mixQ = 34'(pathIn[p].i * sinV) + 34'(pathIn[p].q * cosV);
    // unity drops 15 fraction bits, half-gain one more
    wire signed [33:0] sclI = gainUnity ? (mixI >>> 15) : (mixI >>> 16);
    wire signed [33:0] sclQ = gainUnity ? (mixQ >>> 15) : (mixQ >>> 16);
    wire cxm_iq_t mulOut = '{i: sat16(sclI), q: sat16(sclQ)};
    // quarter turns: +fs/4 adds n, -fs/4 subtracts n, fs/2 adds 2n
    wire [1:0] rotK = (cmix[2] ? idxD : 2'h0) - (cmix[0] ? idxD : 2'h0)
                      + (cmix[1] ? {idxD[0], 1'b0} : 2'h0);

    // accumulator wraps modulo 2^32 (freq = word * fclk / 2^32); bypass gets no gain
    always_ff @(posedge core_clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        acc[p] <= 32'h0;
        stage1[p] <= '0;
        stage2[p] <= '0;
      end
      else
      begin
        acc[p] <= syncEv ? 32'h0 : acc[p] + freqWord[p];
        stage1[p] <= useMul ? mulOut : pathIn[p];
        stage2[p] <= rotQ(stage1[p], rotK);
      end
    end
  end

endmodule

//--- dv/cxm_checker.sv
// handshake and response assertions on the mixer register bus
`timescale 1ns/1ns
module cxm_checker
  import cxm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // only writes whose two halves go in together are tracked
  wire wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire rdTake = s_axi_arvalid && s_axi_arready;
  wire wrMap = s_axi_awaddr < 8'h18 && s_axi_awaddr[1:0] == 2'b00;
  wire rdMap = s_axi_araddr < 8'h20 && s_axi_araddr[1:0] == 2'b00;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr_done;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  a_write_answer: assert property (wrTake |=> s_wr_done)
    else $error("late write answer");
  a_write_okay: assert property (wrTake && wrMap |=> ##1 s_axi_bresp == CXM_RESP_OKAY)
    else $error("mapped write refused");
  a_write_refused: assert property (wrTake && s_axi_awaddr > 8'h1c
    |=> ##1 s_axi_bresp == CXM_RESP_SLVERR)
    else $error("unmapped write accepted");
  a_bvalid_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  a_read_answer: assert property (rdTake |=> s_axi_rvalid && !s_axi_arready)
    else $error("late read answer");
  a_read_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer stuck");
  a_read_refused: assert property (rdTake && !rdMap
    |=> s_axi_rresp == CXM_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read accepted");
  a_read_okay: assert property (rdTake && rdMap |=> s_axi_rresp == CXM_RESP_OKAY)
    else $error("mapped read refused");
endmodule

//--- dv/cxm_sample_source.sv
// upstream sample source: one sample per clock on each path
`timescale 1ns/1ns
module cxm_sample_source
  import cxm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  output cxm_iq_t pair1In,
  output cxm_iq_t pair2In
);
  logic [15:0] cnt;
  // step count, changes just after each edge
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      cnt <= 16'h0000;
    else
      cnt <= cnt + 16'h0001;
  // both signs; every 16th sample most negative on path 1, and in I only on path 2, to probe clipping
  assign pair1In = (cnt[3:0] == 4'h5) ? 32'h8000_8000 : {cnt * 16'h04d3, cnt * 16'hf359};
  assign pair2In = {pair1In.q, pair1In.i ^ 16'h00f0};
endmodule

//--- dv/tb_top.sv
// bench: register access, sync, coarse and full mixing
`timescale 1ns/1ns
module tb_top;
  import cxm_pkg::*;
`define CHK(n, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("[ERR] %s exp %h got %h", n, e, g); \
    end \
  end
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [2:0] syncPin = 3'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
  logic [31:0] s_axi_rdata, rdat, a0;
  cxm_iq_t pair1In, pair2In, pair1Out, pair2Out;
  cxm_iq_t h1 [0:4095];
  cxm_iq_t h2 [0:4095];
  logic [3:0] cm [2];
  logic [3:0] md [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'ha, 4'hc, 4'he};
  int ph [2];
  int errors = 0, cmp_count = 0, cyc = 0, rtk, t0, se, sh;
  bit fm = 1'b0;
  cxm_sample_source i_cxm_sample_source(.core_clk, .rst_b, .pair1In, .pair2In);
  cxm_complex_nco_coarse_mixer i_cxm_complex_nco_coarse_mixer(.core_clk, .rst_b,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .syncPin, .pair1In, .pair2In, .pair1Out, .pair2Out);
  initial
    forever #4 core_clk = ~core_clk;
  // inputs kept by edge number for the output checks
  always @(posedge core_clk)
  begin
    h1[cyc] <= pair1In;
    h2[cyc] <= pair2In;
    cyc <= cyc + 1;
  end
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready && s_axi_awvalid)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    `CHK("bresp", er, s_axi_bresp)
  endtask
  // read; rtk keeps the edge at which the address went in
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready && s_axi_arvalid)
      begin
        s_axi_arvalid <= 1'b0;
        rtk = cyc;
      end
    end
    while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    rd(a);
    `CHK("rdata", e, rdat)
    `CHK("rresp", er, rrsp)
  endtask
  // one-cycle sync level; se is the edge that sees it
  task automatic pulse(input logic [2:0] p);
    syncPin <= p;
    @(posedge core_clk);
    se = cyc;
    syncPin <= 3'h0;
    @(posedge core_clk);
  endtask
  // negating the most negative code clips to the most positive
  function automatic logic [15:0] ng(input logic signed [15:0] v);
    return (v == 16'sh8000) ? 16'h7fff : -v;
  endfunction
  // sine in eighth turns from the quarter table; cosine is two steps on
  function automatic longint s8(input int e);
    case (e & 7)
      1, 3: return longint'(CXM_SIN_TBL[8]);
      2: return longint'(CXM_SIN_TBL[16]);
      5, 7: return -longint'(CXM_SIN_TBL[8]);
      6: return -longint'(CXM_SIN_TBL[16]);
      default: return 0;
    endcase
  endfunction
  // clip a scaled product sum to the sample range
  function automatic logic [15:0] st(input longint x);
    return (x > 32767) ? 16'h7fff : (x < -32768) ? 16'h8000 : x[15:0];
  endfunction
  // multiplier for full mix or fs/8, then quarter turns of the coarse index
  function automatic cxm_iq_t ex(input cxm_iq_t s, input int p, input int n);
    longint c, sn, xi, xq;
    int r;
    cxm_iq_t v;
    c = s8(fm ? 2 * ph[p] + 2 : n + 2);
    sn = s8(fm ? 2 * ph[p] : n);
    xi = (s.i * c - s.q * sn) >>> sh;
    xq = (s.i * sn + s.q * c) >>> sh;
    v = (fm || cm[p][3]) ? {st(xi), st(xq)} : s;
    r = (cm[p][2] ? n : 0) - (cm[p][0] ? n : 0) + (cm[p][1] ? 2 * n : 0);
    case (r & 3)
      1: return {ng(v.q), v.i};
      2: return {ng(v.i), ng(v.q)};
      3: return {v.q, ng(v.i)};
      default: return v;
    endcase
  endfunction
  // output after edge m carries the input of edge m-1
  task automatic run();
    int m;
    repeat (8)
    begin
      @(posedge core_clk);
      m = cyc;
      #1;
      `CHK("path1", ex(h1[m - 1], 0, m - 2 - se), pair1Out)
      `CHK("path2", ex(h2[m - 1], 1, m - 2 - se), pair2Out)
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // cut a hang short; the run needs under 1500 cycles
  initial
  begin
    #40000;
    errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    rchk(CXM_CTRL_OFS, 32'h0, CXM_RESP_OKAY);
    rchk(CXM_SYNC_OFS, 32'h1, CXM_RESP_OKAY);
    rchk(8'h40, 32'h0, CXM_RESP_SLVERR);
    wr(8'h44, 32'h1, CXM_RESP_SLVERR);
    wr(CXM_POFS2_OFS, 32'hffff_1234, CXM_RESP_OKAY);
    rchk(CXM_POFS2_OFS, 32'h1234, CXM_RESP_OKAY);
    wr(CXM_ACC1_OFS, 32'h1, CXM_RESP_SLVERR);
    wr(CXM_FREQ1_OFS, 32'h8000_0001, CXM_RESP_OKAY);
    rd(CXM_ACC1_OFS);
    a0 = rdat;
    t0 = rtk;
    rd(CXM_ACC1_OFS);
    `CHK("acc step", 32'h8000_0001 * 32'(rtk - t0), rdat - a0)
    // software sync: pulse one edge after the write, clear the next
    wr(CXM_CTRL_OFS, 32'h0001_0000, CXM_RESP_OKAY);
    t0 = cyc;
    rd(CXM_ACC1_OFS);
    `CHK("sw sync", 32'h8000_0001 * 32'(rtk - t0 - 1), rdat)
    rchk(CXM_ACC2_OFS, 32'h0, CXM_RESP_OKAY);
    wr(CXM_FREQ1_OFS, 32'h0, CXM_RESP_OKAY);
    wr(CXM_SYNC_OFS, 32'h4, CXM_RESP_OKAY);
    rd(CXM_ACC1_OFS);
    a0 = rdat;
    pulse(3'h1);
    rchk(CXM_ACC1_OFS, a0, CXM_RESP_OKAY);
    pulse(3'h2);
    rchk(CXM_ACC1_OFS, 32'h0, CXM_RESP_OKAY);
    foreach (md[j])
    begin
      cm[0] = md[j];
      cm[1] = md[(j + 1) % 8];
      sh = 16 - j % 2;
      wr(CXM_CTRL_OFS, {16'h0, cm[1], cm[0], 8'h00} | 32'(j % 2) << 2, CXM_RESP_OKAY);
      pulse(3'h2);
      run();
    end
    cm = '{4'h0, 4'h0};
    fm = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      ph[0] = k;
      ph[1] = (k + 1) % 4;
      sh = 16 - k % 2;
      wr(CXM_POFS1_OFS, 32'(k) << 14, CXM_RESP_OKAY);
      wr(CXM_POFS2_OFS, 32'(ph[1]) << 14, CXM_RESP_OKAY);
      wr(CXM_CTRL_OFS, 32'h3 | 32'(k % 2) << 2, CXM_RESP_OKAY);
      pulse(3'h2);
      run();
    end
    tally_and_finish();
  end
endmodule
bind cxm_complex_nco_coarse_mixer cxm_checker i_cxm_checker(.core_clk, .rst_b,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
